// File: core/flash_erase_sequencer.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Link side: shifts command bits in on the serial clock

module flash_link_port
  import flash_erase_pkg::*;
(
  // Serial link
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // Toward the core domain
  input wire logic [7:0] status_i,
  output logic [7:0] op_o,
  output logic [31:0] addr_o,
  output logic [5:0] bits_o
);

  typedef struct packed {
    logic [5:0] bits;
    logic [2:0] phase;
    logic [7:0] op;
    logic [31:0] addr;
    logic [7:0] shift;
    logic drive;
    logic [7:0] sync1;
    logic [7:0] sync2;
  } link_state_type;

  link_state_type r;
  link_state_type next_r;
  logic armed;
  logic [5:0] bits_base;
  logic [7:0] op_next;

  // Frame start marker, preset while deselected
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      armed <= 1'b1;
    end else begin
      armed <= 1'b0;
    end
  end

  // Bit capture and status shift-out
  always_comb begin
    next_r = r;
    bits_base = armed ? '0 : r.bits;
    op_next = {r.op[6:0], si_i};
    next_r.sync1 = status_i;
    next_r.sync2 = r.sync1;
    next_r.phase = armed ? 3'h1 : 3'(r.phase + 3'h1);
    if (armed) begin
      next_r.drive = 1'b0;
    end
    if (bits_base < 6'(CMD_BITS)) begin
      next_r.op = op_next;
    end else begin
      next_r.addr = {r.addr[30:0], si_i};
    end
    // Saturating count keeps overlong frames invalid
    if (bits_base != BITS_MAX) begin
      next_r.bits = 6'(bits_base + 6'h01);
    end
    // Status byte repeats every eight clocks
    if (bits_base == 6'(CMD_BITS - 1) && op_next == OP_READ_STATUS) begin
      next_r.shift = r.sync2;
      next_r.drive = 1'b1;
    end else if (!armed && r.drive) begin
      if (r.phase == 3'h7) begin
        next_r.shift = r.sync2;
      end else begin
        next_r.shift = {r.shift[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sclk_i) begin
    r <= next_r;
  end

  // Words stay still while deselected
  assign op_o = r.op;
  assign addr_o = r.addr;
  assign bits_o = r.bits;
  assign so_o = r.shift[7];
  assign so_oe_o = r.drive & ~cs_n_i;

endmodule

////////////////////////////////////////////////////////////////////////////
// Core side: command decode, erase timing, suspend and resume

module flash_erase_sequencer
  import flash_erase_pkg::*;
#(
  parameter int SECTOR_ERASE_CYCLES = SECTOR_ERASE_CYC,
  parameter int HALF_BLOCK_ERASE_CYCLES = HALF_BLOCK_ERASE_CYC,
  parameter int FULL_BLOCK_ERASE_CYCLES = FULL_BLOCK_ERASE_CYC,
  parameter int WHOLE_ARRAY_ERASE_CYCLES = WHOLE_ARRAY_ERASE_CYC
)
(
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Serial link
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // Configuration
  input wire logic addr4_mode_i,
  input wire logic protect_complement_i,
  input wire logic top_bottom_select_i,
  input wire logic block_protect_bit3_i,
  input wire logic block_protect_bit2_i,
  input wire logic block_protect_bit1_i,
  input wire logic block_protect_bit0_i,
  // Individual lock lookup
  output logic [31:0] lock_addr_o,
  input wire logic lock_hit_i,
  input wire logic any_lock_i,
  // Program engine
  input wire logic program_busy_i,
  output logic program_hold_o,
  // Status
  output logic busy_o,
  output logic write_enable_latch_o,
  output logic suspend_status_flag_o,
  // Array erase strobe
  output logic array_erase_o,
  output logic [31:0] erase_base_o,
  output erase_kind_type erase_kind_o
);

  typedef struct packed {
    logic [2:0] cs_sync;
    erase_state_type est;
    erase_kind_type kind;
    logic [31:0] base;
    logic [31:0] timer;
    logic write_enable_latch;
    logic suspend_status_flag;
    logic sus_prog;
    logic hold;
    logic pulse;
    logic [7:0] status;
  } core_state_type;

  localparam core_state_type CORE_RESET = '{
    cs_sync: 3'h7, est: ER_IDLE, kind: KIND_SECTOR, base: '0,
    timer: '0, write_enable_latch: 1'b0, suspend_status_flag: 1'b0, sus_prog: 1'b0, hold: 1'b0,
    pulse: 1'b0, status: '0};
  localparam logic [31:0] TIMER_LAST = 32'h0000_0001;

  core_state_type r;
  core_state_type next_r;
  logic [7:0] op;
  logic [31:0] addr_raw;
  logic [31:0] addr;
  logic [5:0] bits;
  logic rise;
  logic busy;
  logic len_cmd;
  logic len_addr;
  logic wide_addr;
  logic [3:0] bp;
  logic [9:0] span;
  logic [9:0] bidx;
  logic region_hit;
  logic protected_here;
  logic protected_any;
  logic may_erase;

  flash_link_port link (
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .si_i(si_i),
    .so_o(so_o),
    .so_oe_o(so_oe_o),
    .status_i(r.status),
    .op_o(op),
    .addr_o(addr_raw),
    .bits_o(bits)
  );

  // Frame decode; link words are static once the select rise is seen
  always_comb begin
    rise = r.cs_sync[1] & ~r.cs_sync[2];
    wide_addr = addr4_mode_i || op == OP_SECTOR_ERASE_A4 ||
                op == OP_FULL_BLOCK_ERASE_A4;
    addr = wide_addr ? addr_raw : {8'h00, addr_raw[23:0]};
    // frame ends on a byte edge
    len_cmd = bits == 6'(CMD_BITS);
    len_addr = bits == (wide_addr ? 6'(CMD_BITS + ADDR4_BITS)
                                  : 6'(CMD_BITS + ADDR3_BITS));
  end

  // Protected range from the block protect field
  always_comb begin
    bp = {block_protect_bit3_i, block_protect_bit2_i,
          block_protect_bit1_i, block_protect_bit0_i};
    if (bp == 4'h0) begin
      span = '0;
    end else if (bp >= BP_ALL) begin
      span = BLOCK_COUNT;
    end else begin
      span = 10'(10'h001 << (bp - 4'h1));
    end
    bidx = {1'b0, addr[FULL_BLOCK_LSB +: BLOCK_IDX_W]};
    region_hit = top_bottom_select_i ? (bidx < span)
                                     : (bidx >= 10'(BLOCK_COUNT - span));
    protected_here = (region_hit ^ protect_complement_i) | lock_hit_i;
    protected_any = (protect_complement_i ? (span != BLOCK_COUNT)
                                          : (span != 10'h000)) | any_lock_i;
  end

  // Sequencer next state
  always_comb begin
    next_r = r;
    next_r.cs_sync = {r.cs_sync[1:0], cs_n_i};
    next_r.pulse = 1'b0;
    busy = r.est == ER_RUN || (program_busy_i && !r.hold);
    may_erase = r.write_enable_latch && !busy && !(r.suspend_status_flag && !r.sus_prog);
    if (r.est == ER_RUN) begin
      if (r.timer == TIMER_LAST) begin
        next_r.est = ER_IDLE;
        next_r.write_enable_latch = 1'b0;
        next_r.pulse = 1'b1;
      end else begin
        next_r.timer = 32'(r.timer - TIMER_LAST);
      end
    end
    if (rise) begin
      unique case (op)
        OP_WRITE_ENABLE: begin
          if (len_cmd && !busy) begin
            next_r.write_enable_latch = 1'b1;
          end
        end
        OP_WRITE_DISABLE: begin
          if (len_cmd && !busy) begin
            next_r.write_enable_latch = 1'b0;
          end
        end
        OP_SECTOR_ERASE, OP_SECTOR_ERASE_A4: begin
          if (len_addr && may_erase && !protected_here) begin
            next_r.est = ER_RUN;
            next_r.kind = KIND_SECTOR;
            next_r.base = {addr[31:SECTOR_LSB], SECTOR_LSB'(0)};
            next_r.timer = 32'(SECTOR_ERASE_CYCLES);
          end
        end
        OP_HALF_BLOCK_ERASE: begin
          // half block duration from select rise
          if (len_addr && may_erase && !protected_here) begin
            next_r.est = ER_RUN;
            next_r.kind = KIND_HALF_BLOCK;
            next_r.base = {addr[31:HALF_BLOCK_LSB], HALF_BLOCK_LSB'(0)};
            next_r.timer = 32'(HALF_BLOCK_ERASE_CYCLES);
          end
        end
        OP_FULL_BLOCK_ERASE, OP_FULL_BLOCK_ERASE_A4: begin
          // full block duration from select rise
          if (len_addr && may_erase && !protected_here) begin
            next_r.est = ER_RUN;
            next_r.kind = KIND_FULL_BLOCK;
            next_r.base = {addr[31:FULL_BLOCK_LSB], FULL_BLOCK_LSB'(0)};
            next_r.timer = 32'(FULL_BLOCK_ERASE_CYCLES);
          end
        end
        OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
          if (len_cmd && may_erase && !r.suspend_status_flag && !protected_any) begin
            next_r.est = ER_RUN;
            next_r.kind = KIND_WHOLE_ARRAY;
            next_r.base = '0;
            next_r.timer = 32'(WHOLE_ARRAY_ERASE_CYCLES);
          end
        end
        OP_SUSPEND: begin
          if (len_cmd && !r.suspend_status_flag && busy) begin
            // chip erase not suspendable
            // Finishing erase wins over a late suspend
            if (r.est == ER_RUN && r.kind != KIND_WHOLE_ARRAY &&
                r.timer != TIMER_LAST) begin
              next_r.est = ER_HELD;
              next_r.suspend_status_flag = 1'b1;
              next_r.sus_prog = 1'b0;
            end else if (r.est != ER_RUN) begin
              next_r.hold = 1'b1;
              next_r.suspend_status_flag = 1'b1;
              next_r.sus_prog = 1'b1;
            end
          end
        end
        OP_RESUME: begin
          if (len_cmd && r.suspend_status_flag && !busy) begin
            next_r.suspend_status_flag = 1'b0;
            if (r.sus_prog) begin
              next_r.hold = 1'b0;
            end else begin
              next_r.est = ER_RUN;
            end
          end
        end
        default: begin
        end
      endcase
    end
    // Registered status byte for the link and the pins
    next_r.status = '0;
    next_r.status[ST_BUSY] = next_r.est == ER_RUN ||
                             (program_busy_i && !next_r.hold);
    next_r.status[ST_WEL] = next_r.write_enable_latch;
    next_r.status[ST_SUS] = next_r.suspend_status_flag;
  end

  // State register with enable
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      r <= CORE_RESET;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  // Outputs
  assign lock_addr_o = addr;
  assign program_hold_o = r.hold;
  assign busy_o = r.status[ST_BUSY];
  assign write_enable_latch_o = r.status[ST_WEL];
  assign suspend_status_flag_o = r.status[ST_SUS];
  assign array_erase_o = r.pulse;
  assign erase_base_o = r.base;
  assign erase_kind_o = r.kind;

endmodule

// File: core/flash_erase_pkg.sv
package flash_erase_pkg;

  // Clock rate of the core domain
  localparam int CLK_MHZ = 25;

  // Self-timed erase durations, in microseconds
  localparam int SECTOR_ERASE_US = 50_000;
  localparam int HALF_BLOCK_ERASE_US = 120_000;
  localparam int FULL_BLOCK_ERASE_US = 150_000;
  localparam int WHOLE_ARRAY_ERASE_US = 40_000_000;

  // Durations as clock cycles
  localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_US * CLK_MHZ;
  localparam int HALF_BLOCK_ERASE_CYC = HALF_BLOCK_ERASE_US * CLK_MHZ;
  localparam int FULL_BLOCK_ERASE_CYC = FULL_BLOCK_ERASE_US * CLK_MHZ;
  localparam int WHOLE_ARRAY_ERASE_CYC = WHOLE_ARRAY_ERASE_US * CLK_MHZ;

  // Command opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_SECTOR_ERASE_A4 = 8'h21;
  localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] OP_FULL_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] OP_FULL_BLOCK_ERASE_A4 = 8'hDC;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;

  // Frame lengths in bits
  localparam int CMD_BITS = 8;
  localparam int ADDR3_BITS = 24;
  localparam int ADDR4_BITS = 32;
  localparam logic [5:0] BITS_MAX = 6'h3F;

  // Status byte bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_SUS = 7;

  // Address alignment of each erase unit
  localparam int SECTOR_LSB = 12;
  localparam int HALF_BLOCK_LSB = 15;
  localparam int FULL_BLOCK_LSB = 16;
  localparam int BLOCK_IDX_W = 9;
  localparam logic [9:0] BLOCK_COUNT = 10'h200;
  localparam logic [3:0] BP_ALL = 4'hA;

  typedef enum logic [1:0] {
    KIND_SECTOR, KIND_HALF_BLOCK, KIND_FULL_BLOCK, KIND_WHOLE_ARRAY
  } erase_kind_type;

  typedef enum logic [1:0] {ER_IDLE, ER_RUN, ER_HELD} erase_state_type;

endpackage

// File: verification/flash_host_model.sv
`timescale 1ns/1ps

module flash_host_model (
  // Serial link
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i
);
  logic [7:0] rd;

  // Link idle: clock low, deselected
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    si_o = 1'b0;
    rd = 8'h00;
    // Deselect edge after start presets the frame marker
    #1 cs_n_o = 1'b1;
  end

  // One frame: opcode, then low n-8 address bits, MSB first
  task automatic frame(input logic [7:0] op, input logic [31:0] addr,
                       input int n);
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      #8 si_o = (i < 8) ? op[7 - i] : addr[n - 1 - i];
      #8 sclk_o = 1'b1;
      #16 sclk_o = 1'b0;
      // Status byte: eight bits from the eighth clock on
      if (i >= 7 && i < 15) rd = {rd[6:0], so_i};
    end
    #8 cs_n_o = 1'b1;
    si_o = ~si_o;
  endtask
endmodule

// File: verification/flash_erase_assertions.sv
`timescale 1ns/1ps

module flash_erase_assertions (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic program_busy_i,
  input wire logic busy_o,
  input wire logic write_enable_latch_o,
  input wire logic suspend_status_flag_o,
  input wire logic program_hold_o,
  input wire logic array_erase_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // Step sequences
  sequence s_pulse_end;
    array_erase_o ##1 !array_erase_o;
  endsequence
  sequence s_halted;
    suspend_status_flag_o && !busy_o;
  endsequence

  // Properties
  property p_pulse_one;
    array_erase_o |-> s_pulse_end;
  endproperty
  property p_done_flags;
    array_erase_o |-> !write_enable_latch_o && !busy_o;
  endproperty
  property p_busy_before;
    array_erase_o |-> $past(busy_o);
  endproperty
  property p_sus_cause;
    $rose(suspend_status_flag_o) |-> $past(busy_o) || $past(program_busy_i);
  endproperty
  property p_sus_idle;
    $rose(suspend_status_flag_o) |-> s_halted;
  endproperty
  property p_frozen;
    suspend_status_flag_o && !program_hold_o |-> !array_erase_o;
  endproperty
  property p_hold_sus;
    program_hold_o |-> suspend_status_flag_o;
  endproperty
  property p_resume;
    $fell(suspend_status_flag_o) && !$past(program_hold_o) && !$past(rst_i)
      |-> busy_o;
  endproperty
  property p_reset_clear;
    $fell(rst_i) |-> !suspend_status_flag_o && !busy_o && !program_hold_o;
  endproperty

  // Assertions
  a_pulse_one: assert property (p_pulse_one)
    else $error("erase strobe longer than one cycle");
  a_done_flags: assert property (p_done_flags)
    else $error("flags not cleared at erase end");
  a_busy_before: assert property (p_busy_before)
    else $error("erase ended without busy");
  a_sus_cause: assert property (p_sus_cause)
    else $error("suspend taken while idle");
  a_sus_idle: assert property (p_sus_idle)
    else $error("busy high when suspend taken");
  a_frozen: assert property (p_frozen)
    else $error("erase finished while suspended");
  a_hold_sus: assert property (p_hold_sus)
    else $error("program hold without suspend flag");
  a_resume: assert property (p_resume)
    else $error("resume did not raise busy");
  a_reset_clear: assert property (p_reset_clear)
    else $error("flags not cleared by reset");
endmodule

bind flash_erase_sequencer flash_erase_assertions flash_erase_assertions_i (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .program_busy_i(program_busy_i),
  .busy_o(busy_o),
  .write_enable_latch_o(write_enable_latch_o),
  .suspend_status_flag_o(suspend_status_flag_o),
  .program_hold_o(program_hold_o),
  .array_erase_o(array_erase_o)
);

// File: verification/testbench.sv
`timescale 1ns/1ps

module testbench;
  import flash_erase_pkg::*;

  logic sys_clk, rst, addr4, cmp, tb, lock_hit, any_lock, prog_busy;
  logic sclk, cs_n, si, so, so_oe, hold, busy, write_enable_latch, suspend_status_flag, done;
  logic [3:0] bp;
  logic oe_seen;
  logic [31:0] lock_addr, base;
  erase_kind_type kind;
  int mismatches, check_count, cnt;
  // Erase cases: opcode, address, bits, base, kind, length
  logic [7:0] op_t [5] = '{8'h52, 8'hD8, 8'h21, 8'hC7, 8'h60};
  logic [31:0] ad_t [5] = '{32'h0001_2345, 32'h01AB_CDEF, 32'h0123_4567,
                            32'h0000_0000, 32'h0000_0000};
  logic [31:0] bs_t [5] = '{32'h0001_0000, 32'h01AB_0000, 32'h0123_4000,
                            32'h0000_0000, 32'h0000_0000};
  int nb_t [5] = '{32, 40, 40, 8, 8};
  int du_t [5] = '{300, 400, 200, 600, 600};
  logic [1:0] kd_t [5] = '{2'h1, 2'h2, 2'h0, 2'h3, 2'h3};
  // Protection cases: cmp, tb, lock hit, any lock, bp
  logic [7:0] pr_t [5] = '{8'h0A, 8'h41, 8'h80, 8'h20, 8'h10};
  logic [7:0] po_t [5] = '{8'hD8, 8'h20, 8'h52, 8'h20, 8'hC7};

  flash_erase_sequencer #(
    .SECTOR_ERASE_CYCLES(200),
    .HALF_BLOCK_ERASE_CYCLES(300),
    .FULL_BLOCK_ERASE_CYCLES(400),
    .WHOLE_ARRAY_ERASE_CYCLES(600)
  ) flash_erase_sequencer_i (
    .sys_clk_i(sys_clk), .rst_i(rst), .ce_i(1'b1),
    .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe),
    .addr4_mode_i(addr4), .protect_complement_i(cmp),
    .top_bottom_select_i(tb), .block_protect_bit3_i(bp[3]),
    .block_protect_bit2_i(bp[2]), .block_protect_bit1_i(bp[1]),
    .block_protect_bit0_i(bp[0]), .lock_addr_o(lock_addr),
    .lock_hit_i(lock_hit), .any_lock_i(any_lock),
    .program_busy_i(prog_busy), .program_hold_o(hold), .busy_o(busy),
    .write_enable_latch_o(write_enable_latch), .suspend_status_flag_o(suspend_status_flag),
    .array_erase_o(done), .erase_base_o(base), .erase_kind_o(kind)
  );

  flash_host_model flash_host_model_i (
    .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so)
  );

  // Core clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Busy cycle counter
  always @(posedge sys_clk) begin
    if (busy === 1'b1) cnt <= cnt + 1;
  end

  // Output enable as seen at each link falling edge
  always @(negedge sclk) begin
    oe_seen <= so_oe;
  end

  // Verdict and end of run
  task automatic results;
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Frame, then a gap long enough for decode
  task automatic send(input logic [7:0] op, input logic [31:0] a,
                      input int n);
    flash_host_model_i.frame(op, a, n);
    idle(8);
  endtask

  task automatic wait_done(input int lim);
    int k;
    k = 0;
    while (done !== 1'b1 && k < lim) begin
      idle(1);
      k++;
    end
    chk(done, 1'b1);
  endtask

  task automatic finish_erase(input logic [1:0] k, input logic [31:0] b,
                              input int d);
    wait_done(d + 100);
    chk(kind, k);
    if (k != 2'h3) chk(base, b);
    chk({busy, write_enable_latch}, 2'h0);
    chk(cnt >= d - 2 && cnt <= d + 1, 1'b1);
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    results();
  end

  // Test sequence
  initial begin
    rst = 1'b1;
    {addr4, cmp, tb, lock_hit, any_lock, prog_busy} = 6'h00;
    bp = 4'h0;
    mismatches = 0;
    check_count = 0;
    cnt = 0;
    idle(6);
    rst = 1'b0;
    idle(2);
    chk({suspend_status_flag, busy, write_enable_latch, hold}, 4'h0);
    send(OP_SECTOR_ERASE, 32'h0000_0000, 32);
    chk(busy, 1'b0);
    send(OP_WRITE_ENABLE, 32'h0000_0000, 8);
    send(OP_HALF_BLOCK_ERASE, 32'h0000_0000, 31);
    chk(busy, 1'b0);
    send(OP_HALF_BLOCK_ERASE, 32'h0000_0000, 33);
    chk(busy, 1'b0);
    // Protected units refused
    for (int i = 0; i < 5; i++) begin
      {cmp, tb, lock_hit, any_lock, bp} = pr_t[i];
      send(po_t[i], 32'h0000_5000, (po_t[i] == OP_CHIP_ERASE_A) ? 8 : 32);
      chk(busy, 1'b0);
      chk(lock_addr, 32'h0000_5000);
    end
    {cmp, tb, lock_hit, any_lock, bp} = 8'h00;
    chk(write_enable_latch, 1'b1);
    // Every erase kind
    for (int i = 0; i < 5; i++) begin
      addr4 = (i == 1);
      send(OP_WRITE_ENABLE, 32'h0000_0000, 8);
      cnt = 0;
      send(op_t[i], ad_t[i], nb_t[i]);
      chk(busy, 1'b1);
      finish_erase(kd_t[i], bs_t[i], du_t[i]);
    end
    addr4 = 1'b0;
    // Suspend and resume a sector erase
    send(OP_SUSPEND, 32'h0000_0000, 8);
    chk(suspend_status_flag, 1'b0);
    send(OP_WRITE_ENABLE, 32'h0000_0000, 8);
    cnt = 0;
    send(OP_SECTOR_ERASE, 32'h0000_3456, 32);
    send(OP_WRITE_DISABLE, 32'h0000_0000, 8);
    chk(write_enable_latch, 1'b1);
    send(OP_SUSPEND, 32'h0000_0000, 8);
    chk({suspend_status_flag, busy}, 2'h2);
    flash_host_model_i.frame(OP_READ_STATUS, 32'h0000_0000, 16);
    chk(flash_host_model_i.rd, 8'h82);
    idle(8);
    chk({oe_seen, so_oe}, 2'h2);
    send(OP_FULL_BLOCK_ERASE, 32'h0000_0000, 32);
    send(OP_SUSPEND, 32'h0000_0000, 8);
    chk({suspend_status_flag, busy}, 2'h2);
    send(OP_RESUME, 32'h0000_0000, 8);
    chk({suspend_status_flag, busy}, 2'h1);
    finish_erase(2'h0, 32'h0000_3000, 200);
    send(OP_RESUME, 32'h0000_0000, 8);
    chk(busy, 1'b0);
    // Chip erase cannot be suspended
    send(OP_WRITE_ENABLE, 32'h0000_0000, 8);
    send(OP_CHIP_ERASE_B, 32'h0000_0000, 8);
    send(OP_SUSPEND, 32'h0000_0000, 8);
    chk({suspend_status_flag, busy}, 2'h1);
    wait_done(700);
    // Program suspend, then power loss
    prog_busy = 1'b1;
    send(OP_SUSPEND, 32'h0000_0000, 8);
    chk({hold, suspend_status_flag}, 2'h3);
    rst = 1'b1;
    idle(2);
    rst = 1'b0;
    idle(1);
    chk({hold, suspend_status_flag}, 2'h0);
    results();
  end
endmodule
